// >>> core/dcet_defines.svh
// dcet_defines.svh: offsets, field positions, reset values and timing for the event timer
// assumes: included by bare name from the core files, after the package
`ifndef DCET_DEFINES_SVH
`define DCET_DEFINES_SVH

// register byte offsets on the apb bus
`define DCET_OFF_CTRL     8'h00
`define DCET_OFF_CTRL_SET 8'h04
`define DCET_OFF_CTRL_CLR 8'h08
`define DCET_OFF_HSCTL    8'h0c
`define DCET_OFF_COUNT    8'h10
`define DCET_OFF_RCA      8'h14
`define DCET_OFF_RCB      8'h18

// control word field positions
`define DCET_B_RUN   0
`define DCET_B_LOW   1
`define DCET_B_MID   2
`define DCET_B_HIGH  3
`define DCET_B_PNDB  4
`define DCET_B_ENB   5
`define DCET_B_PNDA  6
`define DCET_B_ENA   7

// reset values
`define DCET_CTRL_RST  8'h00
`define DCET_WORD_RST  16'h0000

// timing: one instruction cycle against the 10 ns system clock
`define DCET_CLK_NS    10
`define DCET_TINST_NS  100
`define DCET_INST_DIV  (`DCET_TINST_NS / `DCET_CLK_NS)

`endif

// >>> core/dcet_pkg.sv
// dcet_pkg.sv: types shared by the event timer files
// assumes: nothing beyond a systemverilog compiler
package dcet_pkg;
    // decoded operating mode
    typedef enum logic [2:0] {
        MODE_PWM_TOGGLE,
        MODE_PWM_PLAIN,
        MODE_EVT_RISE,
        MODE_EVT_FALL,
        MODE_CAPTURE
    } dcet_mode_type;
endpackage

// >>> core/dcet_pin_sync.sv
// dcet_pin_sync.sv: two-stage synchroniser with edge detection for one timer pin
// assumes: pin_in is asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module dcet_pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // pin side
    input  wire logic pin_in,
    // edge pulses, one cycle each
    output logic      rise,
    output logic      fall
);
    logic meta_ff;  // first stage, read only by the second
    logic sync_ff;  // second stage, safe level
    logic last_ff;  // previous safe level for edge detection
    logic [2:0] fill_ff;  // fills with ones after reset, chain primed once the top bit is set
    logic       primed;   // edges trusted only after the chain holds the real pin level

    // synchroniser chain
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
            fill_ff <= 3'h0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            fill_ff <= {fill_ff[1:0], 1'b1};
        end
    end

    // a pin that idles high must not look like a rising edge after reset
    assign primed = fill_ff[2];

    // edges seen on the safe level only
    assign rise = primed & sync_ff & ~last_ff;
    assign fall = primed & ~sync_ff & last_ff;
endmodule
`default_nettype wire

// >>> core/dcet_tick_gen.sv
// dcet_tick_gen.sv: counting-rate strobe, fast clock or instruction-cycle rate
// assumes: clk is the fast internal clock
`timescale 1ns/100ps
`default_nettype none
`include "dcet_defines.svh"
module dcet_tick_gen (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // rate select, 1 = every clock
    input  wire logic high_speed,
    // counting strobe
    output logic      tick
);
    localparam logic [7:0] DIV_LAST = 8'(`DCET_INST_DIV - 1);

    logic [7:0] div_ff;     // instruction-cycle divider
    logic [7:0] nxt_div;
    logic       div_wrap;

    assign div_wrap = (div_ff == DIV_LAST);
    assign nxt_div  = div_wrap ? 8'h00 : div_ff + 8'h01;
    assign tick     = high_speed | div_wrap;

    // free running divider
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            div_ff <= 8'h00;
        else
            div_ff <= nxt_div;
    end
endmodule
`default_nettype wire

// >>> core/dcet_timer.sv
// dcet_timer.sv: 16-bit timer with two reload/capture registers and an apb slave
// assumes: apb3 master on clk, timer pins asynchronous, irq outputs go to a controller
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dcet_defines.svh"
module dcet_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer pins
    input  wire logic        timer_pin_a_in,
    input  wire logic        timer_pin_b_in,
    output logic             timer_pin_a_out,
    output logic             timer_pin_a_oe,
    // interrupt requests
    output logic             irq_a,
    output logic             irq_b
);
    // control flags
    logic        run_ff;        // run control or underflow pending
    logic [2:0]  mode_ff;       // {high, mid, low} mode select
    logic        pend_a_ff;     // pending_a
    logic        pend_b_ff;     // pending_b
    logic        en_a_ff;       // irq_enable_a
    logic        en_b_ff;       // irq_enable_b
    logic        hs_ff;         // high_speed_select
    // data words
    logic [15:0] cnt_ff;        // the counter
    logic [15:0] rca_ff;        // reload_capture_a
    logic [15:0] rcb_ff;        // reload_capture_b
    logic        sel_b_ff;      // next reload comes from b
    logic        pin_a_ff;      // pwm level on pin a
    logic [31:0] prdata_ff;     // read data register

    // next values
    logic [7:0]  nxt_ctrl;
    logic        nxt_pend_a;
    logic        nxt_pend_b;
    logic        nxt_run;
    logic [15:0] nxt_cnt;
    logic [15:0] nxt_rca;
    logic [15:0] nxt_rcb;
    logic        nxt_sel_b;
    logic        nxt_pin_a;
    logic [31:0] nxt_prdata;

    // pin edges and counting strobe
    logic a_rise, a_fall, b_rise, b_fall;
    logic tick;

    // synchronise both pins before any use
    dcet_pin_sync u_sync_a (
        .clk    (clk),
        .sys_rst(sys_rst),
        .pin_in (timer_pin_a_in),
        .rise   (a_rise),
        .fall   (a_fall)
    );
    dcet_pin_sync u_sync_b (
        .clk    (clk),
        .sys_rst(sys_rst),
        .pin_in (timer_pin_b_in),
        .rise   (b_rise),
        .fall   (b_fall)
    );

    // counting rate strobe
    dcet_tick_gen u_tick (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .high_speed(hs_ff),
        .tick      (tick)
    );

    // mode decode from the three select bits
    function automatic dcet_pkg::dcet_mode_type decode_mode(input logic [2:0] m);
        if (m[1])
            return dcet_pkg::MODE_CAPTURE;
        else if (m[2])
            return m[0] ? dcet_pkg::MODE_PWM_TOGGLE : dcet_pkg::MODE_PWM_PLAIN;
        else
            return m[0] ? dcet_pkg::MODE_EVT_FALL : dcet_pkg::MODE_EVT_RISE;
    endfunction

    dcet_pkg::dcet_mode_type mode;
    logic is_pwm, is_evt, is_cap;
    assign mode   = decode_mode(mode_ff);
    assign is_cap = (mode == dcet_pkg::MODE_CAPTURE);
    assign is_pwm = (mode == dcet_pkg::MODE_PWM_TOGGLE) | (mode == dcet_pkg::MODE_PWM_PLAIN);
    assign is_evt = ~is_cap & ~is_pwm;

    // apb decode
    logic acc, wr, rd_setup, hit;
    logic wr_ctrl, wr_set, wr_clr, wr_hs, wr_cnt, wr_rca, wr_rcb;
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_ctrl  = wr & (paddr == `DCET_OFF_CTRL);
    assign wr_set   = wr & (paddr == `DCET_OFF_CTRL_SET);
    assign wr_clr   = wr & (paddr == `DCET_OFF_CTRL_CLR);
    assign wr_hs    = wr & (paddr == `DCET_OFF_HSCTL);
    assign wr_cnt   = wr & (paddr == `DCET_OFF_COUNT);
    assign wr_rca   = wr & (paddr == `DCET_OFF_RCA);
    assign wr_rcb   = wr & (paddr == `DCET_OFF_RCB);
    assign hit      = (paddr == `DCET_OFF_CTRL) | (paddr == `DCET_OFF_CTRL_SET)
                    | (paddr == `DCET_OFF_CTRL_CLR) | (paddr == `DCET_OFF_HSCTL)
                    | (paddr == `DCET_OFF_COUNT) | (paddr == `DCET_OFF_RCA)
                    | (paddr == `DCET_OFF_RCB);
    assign pready   = 1'b1;
    assign pslverr  = acc & ~hit;

    // control word as software sees it
    logic [7:0] ctrl_word;
    assign ctrl_word = {en_a_ff, pend_a_ff, en_b_ff, pend_b_ff, mode_ff, run_ff};

    // software update: full write, bit set or bit clear, legal in every mode
    assign nxt_ctrl = wr_ctrl ? pwdata[7:0]
                    : wr_set  ? (ctrl_word | pwdata[7:0])
                    : wr_clr  ? (ctrl_word & ~pwdata[7:0])
                    : ctrl_word;

    // counter events
    logic cnt_step, unf;
    logic evt_edge, cap_a, cap_b;
    assign evt_edge = (mode == dcet_pkg::MODE_EVT_FALL) ? a_fall : a_rise;
    assign cnt_step = is_cap ? tick
                    : is_pwm ? (run_ff & tick)
                    : (run_ff & evt_edge);
    assign unf      = cnt_step & (cnt_ff == 16'h0000);
    assign cap_a    = is_cap & (mode_ff[0] ? a_fall : a_rise);
    assign cap_b    = is_cap & (mode_ff[2] ? b_fall : b_rise);

    // hardware sets of the pending flags win over software clears
    assign nxt_pend_a = nxt_ctrl[`DCET_B_PNDA] | cap_a
                      | (unf & is_evt)
                      | (unf & is_pwm & ~sel_b_ff);
    assign nxt_pend_b = nxt_ctrl[`DCET_B_PNDB] | cap_b
                      | (is_evt & b_rise)
                      | (unf & is_pwm & sel_b_ff);
    assign nxt_run    = nxt_ctrl[`DCET_B_RUN] | (unf & is_cap);

    // counter next value: software write, reload, or step down
    assign nxt_cnt = wr_cnt ? pwdata[15:0]
                   : (unf & ~is_cap) ? (sel_b_ff ? rcb_ff : rca_ff)
                   : cnt_step ? cnt_ff - 16'h0001
                   : cnt_ff;

    // first reload after a start comes from a, then alternate
    assign nxt_sel_b = ~run_ff | ~is_pwm ? 1'b0 : (unf ? ~sel_b_ff : sel_b_ff);

    // capture wins over a software write in the same cycle
    assign nxt_rca = cap_a ? cnt_ff : (wr_rca ? pwdata[15:0] : rca_ff);
    assign nxt_rcb = cap_b ? cnt_ff : (wr_rcb ? pwdata[15:0] : rcb_ff);

    // pwm pin toggles on each underflow in the toggle mode
    assign nxt_pin_a = (mode == dcet_pkg::MODE_PWM_TOGGLE) ? (pin_a_ff ^ unf) : pin_a_ff;

    // read mux, loaded in the setup phase so data stands in the access phase
    assign nxt_prdata = ~rd_setup ? prdata_ff
                      : (paddr == `DCET_OFF_CTRL)  ? {24'h000000, ctrl_word}
                      : (paddr == `DCET_OFF_HSCTL) ? {31'h00000000, hs_ff}
                      : (paddr == `DCET_OFF_COUNT) ? {16'h0000, cnt_ff}
                      : (paddr == `DCET_OFF_RCA)   ? {16'h0000, rca_ff}
                      : (paddr == `DCET_OFF_RCB)   ? {16'h0000, rcb_ff}
                      : 32'h00000000;

    // control flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {en_a_ff, en_b_ff, mode_ff} <= 5'h00;
            {pend_a_ff, pend_b_ff, run_ff} <= 3'h0;
            hs_ff <= 1'b0;
        end else begin
            en_a_ff   <= nxt_ctrl[`DCET_B_ENA];
            en_b_ff   <= nxt_ctrl[`DCET_B_ENB];
            mode_ff   <= nxt_ctrl[`DCET_B_HIGH:`DCET_B_LOW];
            pend_a_ff <= nxt_pend_a;
            pend_b_ff <= nxt_pend_b;
            run_ff    <= nxt_run;
            hs_ff     <= wr_hs ? pwdata[0] : hs_ff;
        end
    end

    // counter, capture registers and pwm state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff    <= `DCET_WORD_RST;
            rca_ff    <= `DCET_WORD_RST;
            rcb_ff    <= `DCET_WORD_RST;
            sel_b_ff  <= 1'b0;
            pin_a_ff  <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            cnt_ff    <= nxt_cnt;
            rca_ff    <= nxt_rca;
            rcb_ff    <= nxt_rcb;
            sel_b_ff  <= nxt_sel_b;
            pin_a_ff  <= nxt_pin_a;
            prdata_ff <= nxt_prdata;
        end
    end

    // outputs
    assign prdata          = prdata_ff;
    assign timer_pin_a_out = pin_a_ff;
    assign timer_pin_a_oe  = (mode == dcet_pkg::MODE_PWM_TOGGLE);
    assign irq_a = en_a_ff & (pend_a_ff | (is_cap & run_ff));
    assign irq_b = en_b_ff & pend_b_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_evt_pin_b;
        is_evt & b_rise |=> pend_b_ff;
    endproperty
    a_evt_pin_b: assert property (p_evt_pin_b) else $error("pin b edge lost in event mode");

    property p_no_drive;
        is_evt |-> !timer_pin_a_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("pin a driven in event mode");

    property p_cap_runs;
        is_cap & tick & !wr_cnt & (cnt_ff != 16'h0000) ##1 is_cap |-> cnt_ff == $past(cnt_ff) - 16'h0001;
    endproperty
    a_cap_runs: assert property (p_cap_runs) else $error("counter not running in capture");

    property p_cap_copy;
        cap_a |=> rca_ff == $past(cnt_ff);
    endproperty
    a_cap_copy: assert property (p_cap_copy) else $error("capture a missed counter value");

    property p_cap_edge_b;
        is_cap & mode_ff[2] & b_rise & !b_fall & !wr_rcb |=> $stable(rcb_ff);
    endproperty
    a_cap_edge_b: assert property (p_cap_edge_b) else $error("wrong edge captured on b");

    property p_unf_flag;
        is_cap & unf |=> run_ff ##0 (irq_a || !en_a_ff);
    endproperty
    a_unf_flag: assert property (p_unf_flag) else $error("capture underflow not flagged");

    property p_stopped;
        !is_cap & !run_ff & !wr_cnt |=> $stable(cnt_ff);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_gate;
        !en_a_ff |-> !irq_a;
    endproperty
    a_gate: assert property (p_gate) else $error("irq a without enable");

    property p_pwm_reload;
        is_pwm & unf & !wr_cnt & !wr_ctrl & !wr_set & !wr_clr & !wr_rca & !wr_rcb
            |=> cnt_ff == ($past(sel_b_ff) ? rcb_ff : rca_ff)
            ##0 (pend_a_ff | pend_b_ff);
    endproperty
    a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload from wrong register");

    property p_evt_unf;
        is_evt & unf |=> pend_a_ff;
    endproperty
    a_evt_unf: assert property (p_evt_unf) else $error("event underflow not flagged");

    property p_fast;
        hs_ff & is_cap & !wr_cnt |=> cnt_ff == $past(cnt_ff) - 16'h0001;
    endproperty
    a_fast: assert property (p_fast) else $error("fast select not counting each clock");

    property p_sticky;
        pend_a_ff & !wr_ctrl & !wr_clr |=> pend_a_ff;
    endproperty
    a_sticky: assert property (p_sticky) else $error("pending a dropped by itself");

    // main scenarios
    c_pwm_toggle: cover property (is_pwm & timer_pin_a_oe & unf ##[1:200] unf);
    c_cap_both: cover property (cap_a & cap_b);
    c_evt_unf: cover property (is_evt & unf);
    c_cap_unf_irq: cover property (is_cap & unf ##1 irq_a);
endmodule
`default_nettype wire

// >>> tb/dcet_pin_src.sv
// dcet_pin_src.sv: outside signal source on the two timer pins
// assumes: the bench calls set_a and set_b, clk is the bench clock
`timescale 1ns/100ps
`default_nettype none
module dcet_pin_src (
    // bench clock
    input  wire logic clk,
    // pin levels seen by the timer
    output var  logic pin_a,
    output var  logic pin_b
);
    // both pins idle low from time zero
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // move pin a just after an edge, then hold it so edges stay well apart
    task automatic set_a(input logic v);
        @(posedge clk);
        pin_a <= v;
        repeat (6) @(posedge clk);
    endtask
    // same for pin b
    task automatic set_b(input logic v);
        @(posedge clk);
        pin_b <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top.sv: self-checking bench, apb register calls plus pin stimulus
// assumes: dcet_timer and dcet_pin_src are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk;        // 100 mhz clock
    logic        sys_rst;    // async reset, high
    logic [7:0]  paddr;      // apb address
    logic        psel;       // apb select
    logic        penable;    // apb access phase
    logic        pwrite;     // apb direction
    logic [31:0] pwdata;     // apb write data
    logic [31:0] prdata;     // apb read data
    logic        pready;     // apb ready
    logic        pslverr;    // apb error
    wire         pin_a;      // timer pin a
    wire         pin_b;      // timer pin b
    logic        pin_a_out;  // pwm level
    logic        pin_a_oe;   // pwm drive enable
    logic        irq_a;      // interrupt a
    logic        irq_b;      // interrupt b
    logic        err_q;      // last pslverr taken
    logic [31:0] q;          // last read data
    logic [31:0] v1;         // count before an event
    logic [31:0] v2;         // count after an event
    int          t[3];       // pwm toggle times
    int          k;          // pwm toggles seen
    int          fail_count; // mismatches
    int          n_tests;    // comparisons

    dcet_timer u_dut (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .paddr          (paddr),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .timer_pin_a_in (pin_a),
        .timer_pin_b_in (pin_b),
        .timer_pin_a_out(pin_a_out),
        .timer_pin_a_oe (pin_a_oe),
        .irq_a          (irq_a),
        .irq_b          (irq_b)
    );
    dcet_pin_src u_src (
        .clk  (clk),
        .pin_a(pin_a),
        .pin_b(pin_b)
    );

    // clock generator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog, far beyond the expected run length
    initial begin
        #300000;
        fail_count++;
        print_verdict();
    end
    // one apb transfer: setup, access held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // compare a word
    task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // compare a flag, at whatever time the caller samples it
    task automatic cmp1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    // counts and verdict
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        fail_count = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, unmapped address, set and clear strokes
        apb(0, 8'h00, 0);
        cmp32("ctrl", 32'h0, q);
        cmp1("pslverr mapped", 1'b0, err_q);
        apb(0, 8'h0c, 0);
        cmp32("hsctl", 32'h0, q);
        apb(0, 8'h1c, 0);
        cmp32("unmapped", 32'h0, q);
        cmp1("pslverr", 1'b1, err_q);
        apb(1, 8'h04, 32'h90);
        apb(0, 8'h00, 0);
        cmp32("ctrl set", 32'h90, q);
        apb(1, 8'h08, 32'h10);
        apb(0, 8'h00, 0);
        cmp32("ctrl clr", 32'h80, q);
        // event mode, rising pin a, run on
        apb(1, 8'h10, 1);
        apb(1, 8'h14, 7);
        apb(1, 8'h00, 32'ha1);
        u_src.set_a(1);
        u_src.set_a(0);
        apb(0, 8'h10, 0);
        cmp32("evt count", 32'h0, q);
        u_src.set_a(1);
        apb(0, 8'h10, 0);
        cmp32("evt reload", 32'h7, q);
        @(negedge clk);
        cmp1("irq_a", 1'b1, irq_a);
        cmp1("evt oe", 1'b0, pin_a_oe);
        u_src.set_b(1);
        @(negedge clk);
        cmp1("irq_b", 1'b1, irq_b);
        repeat (200) @(posedge clk);
        apb(0, 8'h00, 0);
        cmp32("sticky", 32'hf1, q);
        // falling pin a, then run off freezes counting
        apb(1, 8'h00, 32'h03);
        u_src.set_a(0);
        apb(0, 8'h10, 0);
        cmp32("evt fall", 32'h6, q);
        apb(1, 8'h08, 32'h01);
        u_src.set_a(1);
        u_src.set_a(0);
        apb(0, 8'h10, 0);
        cmp32("evt stop", 32'h6, q);
        // capture mode, fast clock, run flag cleared on entry
        apb(1, 8'h0c, 1);
        apb(1, 8'h00, 32'ha4);
        apb(1, 8'h10, 32'h8000);
        apb(0, 8'h10, 0);
        v1 = q;
        u_src.set_a(1);
        apb(0, 8'h14, 0);
        v2 = q;
        apb(0, 8'h10, 0);
        cmp1("cap window", 1'b1, (v1 > v2) && (v2 > q));
        cmp1("cap running", 1'b1, q < 32'h8000);
        apb(0, 8'h14, 0);
        cmp32("cap stable", v2, q);
        @(negedge clk);
        cmp1("cap irq_a", 1'b1, irq_a);
        // pin b falling trigger selected, rising ignored
        apb(1, 8'h00, 32'hac);
        u_src.set_b(0);
        apb(0, 8'h00, 0);
        cmp32("capb flag", 32'hbc, q);
        apb(0, 8'h18, 0);
        v2 = q;
        cmp1("capb taken", 1'b1, q != 0);
        apb(1, 8'h08, 32'h30);
        u_src.set_b(1);
        apb(0, 8'h18, 0);
        cmp32("capb rise ignored", v2, q);
        u_src.set_b(0);
        apb(0, 8'h00, 0);
        cmp32("capb masked", 32'h9c, q);
        @(negedge clk);
        cmp1("irq_b masked", 1'b0, irq_b);
        // pin a falling trigger selected
        apb(1, 8'h00, 32'h8e);
        u_src.set_a(0);
        apb(0, 8'h00, 0);
        cmp32("capa fall flag", 32'hce, q);
        // capture underflow sets the run flag, shares irq a
        apb(1, 8'h00, 32'h84);
        apb(1, 8'h10, 3);
        repeat (10) @(posedge clk);
        apb(0, 8'h00, 0);
        cmp32("underflow", 32'h85, q);
        @(negedge clk);
        cmp1("uf irq_a", 1'b1, irq_a);
        // counting rate, slow and fast, 100 clocks apart
        apb(1, 8'h0c, 0);
        apb(0, 8'h10, 0);
        v1 = q;
        repeat (97) @(posedge clk);
        apb(0, 8'h10, 0);
        cmp32("slow rate", 32'd10, (v1 - q) & 32'hffff);
        apb(1, 8'h0c, 1);
        apb(0, 8'h10, 0);
        v1 = q;
        repeat (97) @(posedge clk);
        apb(0, 8'h10, 0);
        cmp32("fast rate", 32'd100, (v1 - q) & 32'hffff);
        // pwm toggle, stopped while set up, a reloads first then b
        apb(1, 8'h00, 0);
        apb(1, 8'h14, 3);
        apb(1, 8'h18, 5);
        apb(1, 8'h10, 0);
        apb(1, 8'h00, 32'h0b);
        k = 0;
        for (int i = 0; i < 60 && k < 3; i++) begin
            v1[0] = pin_a_out;
            @(negedge clk);
            if (pin_a_out !== v1[0]) begin
                t[k] = i;
                k++;
            end
        end
        cmp32("gap a", 32'd4, t[1] - t[0]);
        cmp32("gap b", 32'd6, t[2] - t[1]);
        cmp1("pwm oe", 1'b1, pin_a_oe);
        apb(0, 8'h00, 0);
        cmp32("pwm pend", 32'h50, q & 32'h50);
        apb(1, 8'h08, 32'h01);
        apb(0, 8'h10, 0);
        v1 = q;
        apb(0, 8'h10, 0);
        cmp32("pwm stop", v1, q);
        apb(1, 8'h00, 32'h09);
        @(negedge clk);
        cmp1("plain oe", 1'b0, pin_a_oe);
        print_verdict();
    end
endmodule
`default_nettype wire
